//--- mcc_pkg.sv
// Purpose: Shared constants and types for the maintenance console control
// Assumes: 16-bit storage addresses, 8-bit data bytes
// Notes: One-hot state codes; timing counts derived from the 25 MHz clock
package mcc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CLK_HZ = 25000000;
	localparam int DEBOUNCE_US = 5;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] HEX_KEY_MASK = 8'h1f;
	localparam logic [4:0] HEX_LIMIT = 5'h10;

	// Mode selector
	typedef enum logic [2:0]
	{
		MCC_PROCESS = 3'b001,
		MCC_STEP = 3'b010,
		MCC_TEST = 3'b100
	} mcc_mode_e;

	// Test-mode rotary setting
	typedef enum logic [3:0]
	{
		MCC_T_ALTADDR = 4'b0001,
		MCC_T_ALTSTOR = 4'b0010,
		MCC_T_DISPSTOR = 4'b0100,
		MCC_T_KEYBOARD = 4'b1000
	} mcc_test_e;

	// Register display selector
	typedef enum logic [2:0]
	{
		MCC_D_OFF = 3'h0,
		MCC_D_SAR = 3'h1,
		MCC_D_IAR = 3'h2,
		MCC_D_ARR = 3'h3,
		MCC_D_IX1 = 3'h4,
		MCC_D_IX2 = 3'h5
	} mcc_disp_e;

	// Storage access sequencer
	typedef enum logic [3:0]
	{
		MCC_IDLE = 4'b0001,
		MCC_HELD = 4'b0010,
		MCC_WRITE = 4'b0100,
		MCC_EXER = 4'b1000
	} mcc_seq_e;

	typedef struct packed
	{
		logic runStop;
		logic cmpStop;
		logic ioChkStop;
		logic parStop;
		logic storRun;
		logic addrInc;
		logic ioOverlap;
		logic extTest;
	} mcc_sw_s;

	typedef struct packed
	{
		logic invalidAddress;
		logic invalidOpcode;
		logic channelOutbus;
		logic invalidModifier;
		logic ioRegSelect;
		logic otherParity;
	} mcc_err_s;

	localparam int SW_W = $bits(mcc_sw_s);
endpackage : mcc_pkg

//--- mcc_console.sv
// Purpose: Maintenance console control of a small byte processor
// Assumes: Panel inputs asynchronous; processor interface on clk
// Notes: Storage handshake is a one-cycle request with one-cycle reply
//
`timescale 1ns/1ps

module mcc_console
#(
	parameter int DEB_CYC = mcc_pkg::DEBOUNCE_CYC
)
(
	input wire logic clk,
	input wire logic srst,
	input wire mcc_pkg::mcc_mode_e modeSel,
	input wire mcc_pkg::mcc_test_e testSel,
	input wire mcc_pkg::mcc_disp_e dispSel,
	input wire mcc_pkg::mcc_sw_s panelSw,
	input wire logic [mcc_pkg::ADDR_W-1:0] addrDataSw,
	input wire logic startKey,
	input wire logic sysResetKey,
	input wire logic chkResetKey,
	input wire logic keyStrobe,
	input wire logic [7:0] keyCode,
	input wire logic sioPhase1End,
	input wire logic ioXferDone,
	input wire logic ioBusy,
	input wire logic ioError,
	input wire logic cpuCycle,
	input wire logic opEnd,
	input wire logic storCycleEnd,
	input wire mcc_pkg::mcc_err_s parErr,
	input wire logic [mcc_pkg::ADDR_W-1:0] cpuSar,
	input wire logic [mcc_pkg::ADDR_W-1:0] ioLsrData,
	input wire logic ioLsrSel,
	input wire logic [mcc_pkg::ADDR_W-1:0] lsrArr,
	input wire logic [mcc_pkg::ADDR_W-1:0] lsrIx1,
	input wire logic [mcc_pkg::ADDR_W-1:0] lsrIx2,
	input wire logic [mcc_pkg::DATA_W-1:0] storRdData,
	input wire logic storRdValid,
	input wire logic adapterTest,
	input wire logic txBit,
	input wire logic modemRx,
	output logic clkIdle,
	output logic cpuHalt,
	output logic [mcc_pkg::ADDR_W-1:0] sarQ,
	output logic [mcc_pkg::ADDR_W-1:0] iarQ,
	output logic [mcc_pkg::ADDR_W-1:0] psrQ,
	output logic [mcc_pkg::ADDR_W-1:0] dfdrQ,
	output logic [mcc_pkg::DATA_W-1:0] aRegQ,
	output logic [mcc_pkg::DATA_W-1:0] bRegQ,
	output logic [mcc_pkg::DATA_W-1:0] modRegQ,
	output logic storRd,
	output logic storWr,
	output logic [mcc_pkg::DATA_W-1:0] storWrData,
	output logic invAddrChkEn,
	output logic ioResetPulse,
	output logic powerChkClr,
	output logic matchSync,
	output logic cmpLamp,
	output logic stopLamp,
	output logic ioChkLamp,
	output logic cpuChkLamp,
	output logic kbdLocked,
	output logic [mcc_pkg::ADDR_W-1:0] dispData,
	output logic rxTrigger,
	output logic modemTx
);
	import mcc_pkg::*;

	localparam int NSYNC = SW_W + 5;

	function automatic logic isHex(input logic [7:0] k);
		isHex = (k[7:5] == 3'h0) && ((k & HEX_KEY_MASK) < 8'(HEX_LIMIT));
	endfunction : isHex

	// Two-flop synchronisers for panel keys, switches and data; mode, test and display selectors are not synchronised
	logic [NSYNC-1:0] rawIn, meta1Q, meta2Q, stableQ;
	logic [7:0] keyMetaQ, keySyncQ;
	logic [ADDR_W-1:0] swMetaQ, swSyncQ;
	assign rawIn = {panelSw, startKey, sysResetKey, chkResetKey, keyStrobe,
		adapterTest};
	always_ff @(posedge clk)
	begin
		meta1Q <= rawIn;
		meta2Q <= meta1Q;
		keyMetaQ <= keyCode;
		keySyncQ <= keyMetaQ;
		swMetaQ <= addrDataSw;
		swSyncQ <= swMetaQ;
	end

	// Per-bit debounce: accept a level after it holds DEB_CYC cycles
	logic [15:0] debCntQ [NSYNC];
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NSYNC; i++)
		begin
			if (srst)
			begin
				debCntQ[i] <= 16'h0000;
				stableQ[i] <= 1'b0;
			end
			else if (meta2Q[i] == stableQ[i])
				debCntQ[i] <= 16'h0000;
			else if (debCntQ[i] >= 16'(DEB_CYC - 1))
			begin
				stableQ[i] <= meta2Q[i];
				debCntQ[i] <= 16'h0000;
			end
			else
				debCntQ[i] <= debCntQ[i] + 16'h0001;
		end
	end

	mcc_sw_s sw;
	logic startLvl, sysRstLvl, chkRstLvl, keyLvl, adTestLvl;
	logic [4:0] prevQ;
	logic startPress, startRel, sysRstEv, chkRstEv, keyEv;
	assign {sw, startLvl, sysRstLvl, chkRstLvl, keyLvl, adTestLvl} = stableQ;
	always_ff @(posedge clk)
		prevQ <= srst ? 5'h00 : {startLvl, sysRstLvl, chkRstLvl, keyLvl, 1'b0};
	assign startPress = startLvl & ~prevQ[4];
	assign startRel = ~startLvl & prevQ[4];
	assign sysRstEv = sysRstLvl & ~prevQ[3] & (modeSel == MCC_PROCESS);
	assign chkRstEv = chkRstLvl & ~prevQ[2];
	assign keyEv = keyLvl & ~prevQ[1];

	logic hardRst;
	assign hardRst = srst | sysRstEv;

	// Error capture and halt causes
	logic fatalPar, anyPar, compareOn, match, halted;
	assign fatalPar = parErr.invalidAddress | parErr.invalidOpcode |
		parErr.channelOutbus | parErr.invalidModifier | parErr.ioRegSelect;
	assign anyPar = fatalPar | parErr.otherParity;
	assign compareOn = (dispSel == MCC_D_SAR) && (modeSel == MCC_PROCESS);
	assign match = compareOn && (swSyncQ == sarQ);

	logic parHaltQ, ioHaltQ, cmpHaltQ, runHaltQ, cmpPendQ;
	always_ff @(posedge clk)
	begin
		if (hardRst || chkRstEv)
		begin
			parHaltQ <= 1'b0;
			ioHaltQ <= 1'b0;
			ioChkLamp <= 1'b0;
			cpuChkLamp <= 1'b0;
		end
		else
		begin
			// Check reset or system reset wins over a simultaneous set
			if ((sw.parStop && anyPar) || fatalPar)
				parHaltQ <= 1'b1;
			if (anyPar)
				cpuChkLamp <= 1'b1;
			if (sw.ioChkStop && ioError)
			begin
				ioHaltQ <= 1'b1;
				ioChkLamp <= 1'b1;
				cpuChkLamp <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (hardRst)
		begin
			cmpPendQ <= 1'b0;
			cmpHaltQ <= 1'b0;
			matchSync <= 1'b0;
			cmpLamp <= 1'b0;
		end
		else
		begin
			matchSync <= match && !sw.cmpStop;
			cmpLamp <= match && sw.cmpStop;
			if (match && sw.cmpStop)
				cmpPendQ <= 1'b1;
			else if (storCycleEnd || !sw.cmpStop)
				cmpPendQ <= 1'b0;
			// A match left over from stop must not halt once at run
			if (cmpPendQ && storCycleEnd && sw.cmpStop)
				cmpHaltQ <= 1'b1;
			else if (startPress)
				cmpHaltQ <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (hardRst)
		begin
			runHaltQ <= 1'b0;
			stopLamp <= 1'b0;
		end
		else if (sw.runStop && opEnd)
		begin
			runHaltQ <= 1'b1;
			stopLamp <= 1'b1;
		end
		else if (!sw.runStop)
		begin
			runHaltQ <= 1'b0;
			stopLamp <= 1'b0;
		end
	end

	assign halted = parHaltQ | ioHaltQ | cmpHaltQ | runHaltQ;

	// Clock idle: start I/O hold, overlap-off hold
	logic sioHoldQ;
	always_ff @(posedge clk)
	begin
		if (hardRst)
			sioHoldQ <= 1'b0;
		else if (sioPhase1End)
			sioHoldQ <= 1'b1;
		else if (ioXferDone)
			sioHoldQ <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			clkIdle <= 1'b1;
			cpuHalt <= 1'b1;
		end
		else
		begin
			clkIdle <= sysRstEv || sioHoldQ || (!sw.ioOverlap && ioBusy);
			cpuHalt <= halted || sysRstEv || (modeSel != MCC_PROCESS);
		end
	end

	always_ff @(posedge clk)
	begin
		ioResetPulse <= hardRst;
		powerChkClr <= sysRstEv;
		invAddrChkEn <= srst ? 1'b0 : (modeSel != MCC_TEST);
	end

	// Test-mode storage sequencer
	mcc_seq_e seqQ;
	logic [3:0] nibQ;
	logic haveNibQ, wrDispQ;
	logic testMode, doInc;
	assign testMode = (modeSel == MCC_TEST);
	// Keyboard entry bumps the address itself; only alter/display use this
	assign doInc = sw.addrInc && ((testSel == MCC_T_ALTSTOR) ||
		(testSel == MCC_T_DISPSTOR));

	always_ff @(posedge clk)
	begin
		if (hardRst)
		begin
			seqQ <= MCC_IDLE;
			sarQ <= ADDR_RESET;
			iarQ <= ADDR_RESET;
			psrQ <= ADDR_RESET;
			dfdrQ <= ADDR_RESET;
			aRegQ <= BYTE_RESET;
			bRegQ <= BYTE_RESET;
			modRegQ <= BYTE_RESET;
			storRd <= 1'b0;
			storWr <= 1'b0;
			storWrData <= BYTE_RESET;
			nibQ <= 4'h0;
			haveNibQ <= 1'b0;
			kbdLocked <= 1'b0;
			wrDispQ <= 1'b0;
		end
		else
		begin
			storRd <= 1'b0;
			storWr <= 1'b0;
			if (!testMode)
				sarQ <= cpuSar;
			if (storRdValid)
				bRegQ <= storRdData;
			if (storWr && doInc)
				sarQ <= sarQ + 16'h0001;
			case (seqQ)
				MCC_IDLE:
				begin
					if (testMode && startPress)
					begin
						case (testSel)
							MCC_T_ALTADDR:
							begin
								iarQ <= swSyncQ;
								sarQ <= swSyncQ;
							end
							MCC_T_ALTSTOR:
							begin
								aRegQ <= swSyncQ[DATA_W-1:0];
								wrDispQ <= 1'b0;
								seqQ <= sw.storRun ? MCC_EXER : MCC_HELD;
							end
							MCC_T_DISPSTOR:
							begin
								storRd <= 1'b1;
								wrDispQ <= 1'b1;
								seqQ <= sw.storRun ? MCC_EXER : MCC_HELD;
							end
							default:
							begin
							end
						endcase
					end
					else if (testMode && testSel == MCC_T_KEYBOARD && keyEv
						&& !kbdLocked)
					begin
						if (!isHex(keySyncQ))
							kbdLocked <= 1'b1;
						else if (!haveNibQ)
						begin
							nibQ <= keySyncQ[3:0];
							haveNibQ <= 1'b1;
						end
						else
						begin
							storWr <= 1'b1;
							storWrData <= {nibQ, keySyncQ[3:0]};
							modRegQ <= {nibQ, keySyncQ[3:0]};
							haveNibQ <= 1'b0;
							sarQ <= sarQ + 16'h0001;
						end
					end
				end
				MCC_HELD:
					if (startRel)
						seqQ <= MCC_WRITE;
				MCC_WRITE:
				begin
					storWr <= 1'b1;
					storWrData <= wrDispQ ? bRegQ : aRegQ;
					modRegQ <= wrDispQ ? bRegQ : aRegQ;
					seqQ <= MCC_IDLE;
				end
				MCC_EXER:
				begin
					// Writes repeat, each after a read when displaying, until the switch leaves run or the mode leaves test
					if (!sw.storRun || !testMode)
						seqQ <= MCC_IDLE;
					else if (wrDispQ && !storRd && !storRdValid)
						storRd <= 1'b1;
					else if (!wrDispQ || storRdValid)
					begin
						storWr <= 1'b1;
						storWrData <= wrDispQ ? storRdData : aRegQ;
						modRegQ <= wrDispQ ? storRdData : aRegQ;
					end
				end
				default:
					seqQ <= MCC_IDLE;
			endcase
		end
	end

	// Register display; frozen on I/O check stop
	logic idleForDisp;
	assign idleForDisp = halted || (!cpuCycle && !ioBusy);
	always_ff @(posedge clk)
	begin
		if (hardRst)
			dispData <= ADDR_RESET;
		else if (!ioHaltQ)
		begin
			if (dispSel == MCC_D_OFF)
				dispData <= ioLsrSel ? ioLsrData : ADDR_RESET;
			else if (dispSel == MCC_D_SAR)
				dispData <= sarQ;
			else if (ioLsrSel && !idleForDisp)
				dispData <= ioLsrData;
			else if (idleForDisp)
			begin
				case (dispSel)
					MCC_D_IAR: dispData <= iarQ;
					MCC_D_ARR: dispData <= lsrArr;
					MCC_D_IX1: dispData <= lsrIx1;
					MCC_D_IX2: dispData <= lsrIx2;
					default: dispData <= ADDR_RESET;
				endcase
			end
		end
	end

	// Adapter loopback
	logic rxMetaQ, rxSyncQ;
	always_ff @(posedge clk)
	begin
		rxMetaQ <= modemRx;
		rxSyncQ <= rxMetaQ;
		if (srst)
		begin
			rxTrigger <= 1'b0;
			modemTx <= 1'b0;
		end
		else
		begin
			modemTx <= txBit;
			if (adTestLvl && !sw.extTest)
				rxTrigger <= txBit;
			else
				rxTrigger <= rxSyncQ;
		end
	end

	chk_halt_cause: assert property (@(posedge clk) disable iff (srst)
		fatalPar && !hardRst && !chkRstEv |=> parHaltQ ##1 cpuHalt)
		else $error("fatal parity did not halt");
	chk_sio_idle: assert property (@(posedge clk) disable iff (srst)
		sioPhase1End && !hardRst |=> ##1 clkIdle)
		else $error("clock not idled after start I/O");
	chk_run_sync: assert property (@(posedge clk) disable iff (srst)
		match && !sw.cmpStop && !hardRst |=> matchSync && !cmpHaltQ)
		else $error("sync wrong at compare run");
	chk_cmp_lamp: assert property (@(posedge clk) disable iff (srst)
		cmpLamp |-> $past(dispSel) == MCC_D_SAR && $past(sw.cmpStop))
		else $error("compare lamp without cause");
	chk_kbd_lock: assert property (@(posedge clk) disable iff (srst)
		kbdLocked && !sysRstEv |=> kbdLocked)
		else $error("keyboard unlocked without reset");
	chk_sys_reset: assert property (@(posedge clk) disable iff (srst)
		sysRstEv |=> iarQ == 16'h0000 && psrQ == 16'h0000 && dfdrQ == 16'h0000)
		else $error("system reset left registers set");
	chk_io_stop: assert property (@(posedge clk) disable iff (srst)
		sw.ioChkStop && ioError && !hardRst && !chkRstEv |=> ioChkLamp && cpuChkLamp)
		else $error("I/O check lamps not lit");
	chk_test_noinv: assert property (@(posedge clk) disable iff (srst)
		modeSel == MCC_TEST |=> !invAddrChkEn)
		else $error("invalid address check in test mode");
	chk_alt_write: assert property (@(posedge clk) disable iff (srst)
		seqQ == MCC_WRITE && !hardRst |=> storWr && modRegQ == storWrData)
		else $error("release write missing");
	cov_cmp_stop: cover property (@(posedge clk) cmpPendQ ##1 cmpHaltQ);
	cov_kbd_byte: cover property (@(posedge clk) haveNibQ ##[1:50] storWr);
	cov_exer: cover property (@(posedge clk) seqQ == MCC_EXER ##1 storWr);
	cov_lock: cover property (@(posedge clk) $rose(kbdLocked));
endmodule : mcc_console

//--- mcc_panel_model.sv
// Purpose: Service engineer panel keys and keyboard for the console
// Assumes: Keys are plain levels, released low
// Notes: Every key is held well past sync and debounce
`timescale 1ns/1ps

module mcc_panel_model
#(
	parameter int HOLD = 8
)
(
	input wire logic clk,
	output logic startKey,
	output logic sysResetKey,
	output logic chkResetKey,
	output logic keyStrobe,
	output logic [7:0] keyCode
);
	initial
	begin
		{startKey, sysResetKey, chkResetKey, keyStrobe} = 4'h0;
		keyCode = 8'h00;
	end

	// Whole HOLD window per level, so each edge is seen once
	task automatic set_key(input int which, input logic lvl);
		@(posedge clk);
		case (which)
			0: startKey <= lvl;
			1: sysResetKey <= lvl;
			2: chkResetKey <= lvl;
			default: keyStrobe <= lvl;
		endcase
		repeat (HOLD) @(posedge clk);
		#1;
	endtask : set_key

	task automatic tap(input int which);
		set_key(which, 1'b1);
		set_key(which, 1'b0);
	endtask : tap

	// Code settles before the strobe and stays after it
	task automatic type_key(input logic [7:0] code);
		@(posedge clk);
		keyCode <= code;
		tap(3);
	endtask : type_key
endmodule : mcc_panel_model

//--- tb.sv
// Purpose: Self-checking bench for the maintenance console control
// Assumes: Debounce shortened to 2 cycles; keys from the panel model
// Notes: Storage reads answered one cycle after each read pulse
`timescale 1ns/1ps

module tb;
	import mcc_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	mcc_mode_e modeSel = MCC_TEST;
	mcc_test_e testSel = MCC_T_ALTADDR;
	mcc_disp_e dispSel = MCC_D_OFF;
	mcc_sw_s panelSw = '0;
	mcc_err_s parErr = '0;
	logic [ADDR_W-1:0] addrDataSw = 16'h0000;
	logic [ADDR_W-1:0] cpuSar = 16'h0000;
	logic [ADDR_W-1:0] lsrArr = 16'h0000;
	logic [ADDR_W-1:0] lsrIx1 = 16'h0000;
	logic [ADDR_W-1:0] lsrIx2 = 16'h0000;
	logic [ADDR_W-1:0] ioLsrData = 16'h0000;
	logic ioLsrSel = 1'b0;
	logic ioBusy = 1'b0;
	logic cpuCycle = 1'b0;
	logic opEnd = 1'b0;
	logic [DATA_W-1:0] storRdData = 8'h00;
	logic [3:0] cpuEv = 4'h0;
	logic storRdValid = 1'b0;
	logic adapterTest = 1'b0;
	logic txBit = 1'b0;
	logic modemRx = 1'b0;
	logic startKey, sysResetKey, chkResetKey, keyStrobe;
	logic [7:0] keyCode;
	logic clkIdle, cpuHalt, storRd, storWr, invAddrChkEn, matchSync;
	logic cmpLamp, ioChkLamp, cpuChkLamp, kbdLocked, rxTrigger, modemTx;
	logic [ADDR_W-1:0] sarQ, iarQ, psrQ, dfdrQ, dispData;
	logic [DATA_W-1:0] aRegQ, bRegQ, modRegQ, storWrData, wrData;
	int mismatches = 0;
	int comparisons = 0;
	int wrCnt = 0;

	always #20 clk = ~clk;

	mcc_panel_model #(.HOLD(8)) panel_u
	(
		.clk(clk), .startKey(startKey), .sysResetKey(sysResetKey),
		.chkResetKey(chkResetKey), .keyStrobe(keyStrobe), .keyCode(keyCode)
	);

	mcc_console #(.DEB_CYC(2)) dut_u
	(
		.clk(clk), .srst(srst), .modeSel(modeSel), .testSel(testSel),
		.dispSel(dispSel), .panelSw(panelSw), .addrDataSw(addrDataSw),
		.startKey(startKey), .sysResetKey(sysResetKey),
		.chkResetKey(chkResetKey), .keyStrobe(keyStrobe), .keyCode(keyCode),
		.sioPhase1End(cpuEv[2]), .ioXferDone(cpuEv[3]), .ioBusy(ioBusy),
		.ioError(cpuEv[1]), .cpuCycle(cpuCycle), .opEnd(opEnd),
		.storCycleEnd(cpuEv[0]), .parErr(parErr), .cpuSar(cpuSar),
		.ioLsrData(ioLsrData), .ioLsrSel(ioLsrSel), .lsrArr(lsrArr),
		.lsrIx1(lsrIx1), .lsrIx2(lsrIx2), .storRdData(storRdData),
		.storRdValid(storRdValid), .adapterTest(adapterTest),
		.txBit(txBit), .modemRx(modemRx), .clkIdle(clkIdle),
		.cpuHalt(cpuHalt), .sarQ(sarQ), .iarQ(iarQ), .psrQ(psrQ),
		.dfdrQ(dfdrQ), .aRegQ(aRegQ), .bRegQ(bRegQ), .modRegQ(modRegQ),
		.storRd(storRd), .storWr(storWr), .storWrData(storWrData),
		.invAddrChkEn(invAddrChkEn), .ioResetPulse(), .powerChkClr(),
		.matchSync(matchSync), .cmpLamp(cmpLamp), .stopLamp(),
		.ioChkLamp(ioChkLamp), .cpuChkLamp(cpuChkLamp),
		.kbdLocked(kbdLocked), .dispData(dispData),
		.rxTrigger(rxTrigger), .modemTx(modemTx)
	);

	// Write strobes last one cycle, so every edge is watched
	always @(posedge clk)
	begin
		storRdValid <= storRd;
		if (storRd === 1'b1)
			storRdData <= sarQ[7:0] ^ 8'h3c;
		if (storWr === 1'b1)
		begin
			wrCnt <= wrCnt + 1;
			wrData <= storWrData;
		end
	end

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task pulse(input logic [3:0] ev);
		@(posedge clk);
		cpuEv <= ev;
		@(posedge clk);
		cpuEv <= 4'h0;
		tick(3);
	endtask : pulse

	task sc_alter;
		int n;
		@(posedge clk);
		addrDataSw <= 16'h1234;
		panel_u.tap(0);
		chk(sarQ, 16'h1234);
		chk(iarQ, 16'h1234);
		@(posedge clk);
		testSel <= MCC_T_ALTSTOR;
		addrDataSw <= 16'h12a5;
		panelSw.addrInc <= 1'b1;
		n = wrCnt;
		panel_u.set_key(0, 1'b1);
		chk(16'(aRegQ), 16'h00a5);
		chk(16'(wrCnt - n), 16'h0000);
		panel_u.set_key(0, 1'b0);
		chk(16'(wrData), 16'h00a5);
		chk(16'(modRegQ), 16'h00a5);
		chk(sarQ, 16'h1235);
		@(posedge clk);
		testSel <= MCC_T_DISPSTOR;
		panelSw.addrInc <= 1'b0;
		panel_u.set_key(0, 1'b1);
		chk(16'(bRegQ), 16'h0009);
		panel_u.set_key(0, 1'b0);
		chk(16'(wrCnt - n), 16'h0002);
		chk(16'(modRegQ), 16'h0009);
		chk(sarQ, 16'h1235);
	endtask : sc_alter

	task sc_keyboard;
		int n;
		@(posedge clk);
		testSel <= MCC_T_KEYBOARD;
		panelSw.addrInc <= 1'b1;
		n = wrCnt;
		panel_u.type_key(8'h0c);
		chk(16'(wrCnt - n), 16'h0000);
		panel_u.type_key(8'h03);
		chk(16'(wrData), 16'h00c3);
		chk(sarQ, 16'h1236);
		panel_u.type_key(8'h10);
		chk(16'(kbdLocked), 16'h0001);
		panel_u.type_key(8'h05);
		panel_u.type_key(8'h06);
		chk(16'(wrCnt - n), 16'h0001);
		panel_u.tap(1);
		chk(16'(kbdLocked), 16'h0001);
		@(posedge clk);
		modeSel <= MCC_PROCESS;
		panel_u.tap(1);
		chk(16'(kbdLocked), 16'h0000);
		chk(iarQ, 16'h0000);
		chk(psrQ | dfdrQ, 16'h0000);
	endtask : sc_keyboard

	task sc_compare;
		@(posedge clk);
		dispSel <= MCC_D_SAR;
		cpuSar <= 16'h0400;
		addrDataSw <= 16'h0400;
		panelSw.cmpStop <= 1'b1;
		tick(8);
		chk(16'(cmpLamp), 16'h0001);
		chk(16'(cpuHalt), 16'h0000);
		pulse(4'h1);
		chk(16'(cpuHalt), 16'h0001);
		panel_u.tap(0);
		chk(16'(cpuHalt), 16'h0000);
		@(posedge clk);
		panelSw.cmpStop <= 1'b0;
		tick(8);
		chk(16'(cmpLamp), 16'h0000);
		chk(16'(matchSync), 16'h0001);
		pulse(4'h1);
		chk(16'(cpuHalt), 16'h0000);
		@(posedge clk);
		dispSel <= MCC_D_ARR;
		lsrArr <= 16'h5aa5;
		tick(4);
		chk(16'(matchSync), 16'h0000);
		chk(dispData, 16'h5aa5);
		@(posedge clk);
		dispSel <= MCC_D_OFF;
		tick(4);
		chk(dispData, 16'h0000);
	endtask : sc_compare

	task sc_checks;
		@(posedge clk);
		parErr.otherParity <= 1'b1;
		@(posedge clk);
		parErr <= '0;
		tick(3);
		chk(16'(cpuHalt), 16'h0000);
		@(posedge clk);
		parErr.invalidOpcode <= 1'b1;
		@(posedge clk);
		parErr <= '0;
		tick(3);
		chk(16'(cpuHalt), 16'h0001);
		panel_u.tap(2);
		panel_u.tap(0);
		chk(16'(cpuHalt), 16'h0000);
		@(posedge clk);
		panelSw.ioChkStop <= 1'b1;
		tick(6);
		pulse(4'h2);
		chk(16'({cpuHalt, ioChkLamp, cpuChkLamp}), 16'h0007);
		panel_u.tap(2);
		chk(16'(ioChkLamp), 16'h0000);
		panel_u.tap(0);
		pulse(4'h4);
		chk(16'(clkIdle), 16'h0001);
		pulse(4'h8);
		chk(16'(clkIdle), 16'h0000);
	endtask : sc_checks

	task sc_run;
		@(posedge clk);
		panelSw.runStop <= 1'b1;
		tick(6);
		@(posedge clk);
		opEnd <= 1'b1;
		@(posedge clk);
		opEnd <= 1'b0;
		tick(3);
		chk(16'(cpuHalt), 16'h0001);
		@(posedge clk);
		panelSw.runStop <= 1'b0;
		tick(8);
		chk(16'(cpuHalt), 16'h0000);
		@(posedge clk);
		ioBusy <= 1'b1;
		tick(3);
		chk(16'(clkIdle), 16'h0001);
		@(posedge clk);
		panelSw.ioOverlap <= 1'b1;
		dispSel <= MCC_D_IX1;
		lsrIx1 <= 16'h1111;
		lsrIx2 <= 16'h2222;
		ioLsrData <= 16'h7777;
		ioLsrSel <= 1'b1;
		cpuCycle <= 1'b1;
		tick(8);
		chk(16'(clkIdle), 16'h0000);
		chk(dispData, 16'h7777);
		@(posedge clk);
		ioLsrSel <= 1'b0;
		ioBusy <= 1'b0;
		cpuCycle <= 1'b0;
		tick(3);
		chk(dispData, 16'h1111);
		@(posedge clk);
		dispSel <= MCC_D_IX2;
		tick(3);
		chk(dispData, 16'h2222);
		@(posedge clk);
		dispSel <= MCC_D_OFF;
		ioLsrSel <= 1'b1;
		tick(3);
		chk(dispData, 16'h7777);
		@(posedge clk);
		ioLsrSel <= 1'b0;
		tick(3);
	endtask : sc_run

	task sc_loop;
		@(posedge clk);
		adapterTest <= 1'b1;
		txBit <= 1'b1;
		tick(8);
		chk(16'(rxTrigger), 16'h0001);
		@(posedge clk);
		txBit <= 1'b0;
		panelSw.extTest <= 1'b1;
		tick(8);
		chk(16'(rxTrigger), 16'h0000);
		@(posedge clk);
		txBit <= 1'b1;
		tick(8);
		chk(16'({modemTx, rxTrigger}), 16'h0002);
		@(posedge clk);
		modemRx <= 1'b1;
		tick(8);
		chk(16'(rxTrigger), 16'h0001);
	endtask : sc_loop

	task results;
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		tick(2);
		chk(sarQ, 16'h0000);
		chk(16'(invAddrChkEn), 16'h0000);
		sc_alter();
		sc_keyboard();
		sc_compare();
		sc_checks();
		sc_run();
		sc_loop();
		results();
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("Error at %0t: run did not finish", $time);
		results();
	end
endmodule : tb
